// ===== inc/qdl_consts.svh
// Offsets, field positions, reset values and timing counts of the quad loader
`ifndef QDL_CONSTS_SVH
`define QDL_CONSTS_SVH

`define QDL_WORD_BITS      16
`define QDL_CODE_BITS      12
`define QDL_CODE_MSB       11
`define QDL_SPEED_BIT      12
`define QDL_SLEEP_BIT      13
`define QDL_SEL_LO_BIT     14
`define QDL_SEL_HI_BIT     15
`define QDL_LAST_BIT_IDX   4'hf
`define QDL_CHANNELS       4

`define QDL_CLK_NS         20
`define QDL_SCLK_HALF_NS   80
`define QDL_SCLK_HALF_CYC  (((`QDL_SCLK_HALF_NS) + (`QDL_CLK_NS) - 1) / (`QDL_CLK_NS))
`define QDL_LATCH_UPDATE_N_NS        100
`define QDL_LATCH_UPDATE_N_CYC       (((`QDL_LATCH_UPDATE_N_NS) + (`QDL_CLK_NS) - 1) / (`QDL_CLK_NS))

`define QDL_OFS_CTRL       4'h0
`define QDL_OFS_DATA       4'h4
`define QDL_OFS_LATCH      4'h8
`define QDL_OFS_STATUS     4'hc
`define QDL_CTRL_SEL_EN    0
`define QDL_CTRL_HW_PD     1
`define QDL_STAT_BUSY      0
`define QDL_STAT_LATCH     1
`define QDL_CTRL_RESET     2'h0
`define QDL_RESP_OKAY      2'h0
`define QDL_RESP_SLVERR    2'h2

`endif

// ===== inc/qdl_pkg.sv
// Types shared by both ends of the quad loader link
`default_nettype none
package qdl_pkg;
  typedef logic [11:0] qdl_code_type;
  typedef logic [15:0] qdl_word_type;

  typedef enum logic [2:0] {
    QDL_D_IDLE  = 3'b001,
    QDL_D_SHIFT = 3'b010,
    QDL_D_WAIT  = 3'b100
  } qdl_dev_state_type;

  typedef enum logic [5:0] {
    QDL_C_IDLE  = 6'b000001,
    QDL_C_SEL   = 6'b000010,
    QDL_C_HIGH  = 6'b000100,
    QDL_C_LOW   = 6'b001000,
    QDL_C_TAIL  = 6'b010000,
    QDL_C_DONE  = 6'b100000
  } qdl_ctl_state_type;
endpackage : qdl_pkg
`default_nettype wire

// ===== inc/qdl_link_if.sv
// Serial link between the controller and the quad converter loader
`default_nettype none
interface qdl_link_if;
  logic sclk;
  logic sdata;
  logic frame_sync;
  logic device_select_n;
  logic latch_update_n;
  logic hw_powerdown_n;

  modport ctl (
    output sclk,
    output sdata,
    output frame_sync,
    output device_select_n,
    output latch_update_n,
    output hw_powerdown_n
  );

  modport dev (
    input sclk,
    input sdata,
    input frame_sync,
    input device_select_n,
    input latch_update_n,
    input hw_powerdown_n
  );
endinterface : qdl_link_if
`default_nettype wire

// ===== rtl/qdl_device.sv
// Device end: serial word loader, channel latches and output update
`include "qdl_consts.svh"
`default_nettype none
module qdl_device
  import qdl_pkg::*;
(
  // Clock and power-on reset
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  // Serial link
  qdl_link_if.dev                          link,
  // Converter side
  output logic [`QDL_CHANNELS-1:0][11:0]   chan_code,
  output logic [`QDL_CHANNELS-1:0]         chan_fast,
  output logic                             amp_enable,
  output logic                             word_loaded
);

  localparam int NSYNC = 5;

  logic [NSYNC-1:0]         sync1_r;
  logic [NSYNC-1:0]         sync2_r;
  logic [NSYNC-1:0]         prev_r;
  logic                     sclk_s;
  logic                     sdata_s;
  logic                     fs_s;
  logic                     sel_n_s;
  logic                     latch_update_n_n_s;
  logic                     sclk_fall;
  logic                     sclk_rise;
  logic                     fs_fall;
  logic                     fs_rise;
  qdl_dev_state_type        state_r;
  logic [3:0]               bit_cnt_r;
  qdl_word_type             shift_r;
  logic                     xfer;
  logic [1:0]               xfer_chan;
  logic [`QDL_CHANNELS-1:0][11:0] latch_code_r;
  logic [`QDL_CHANNELS-1:0] latch_fast_r;
  logic [`QDL_CHANNELS-1:0] latch_sleep_r;
  logic                     sleep_r;
  logic                     hw_pd_s1_r;
  logic                     hw_pd_s2_r;

  // Two-stage capture of every link pin
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sync1_r <= 5'h1c;
      sync2_r <= 5'h1c;
      prev_r  <= 5'h1c;
    end
    else
    begin
      sync1_r <= {link.latch_update_n, link.device_select_n, link.frame_sync,
                  link.sdata, link.sclk};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      hw_pd_s1_r <= 1'b1;
      hw_pd_s2_r <= 1'b1;
    end
    else
    begin
      hw_pd_s1_r <= link.hw_powerdown_n;
      hw_pd_s2_r <= hw_pd_s1_r;
    end
  end

  assign sclk_s    = sync2_r[0];
  assign sdata_s   = sync2_r[1];
  assign fs_s      = sync2_r[2];
  assign sel_n_s   = sync2_r[3];
  assign latch_update_n_n_s  = sync2_r[4];
  assign sclk_fall = prev_r[0] & ~sclk_s;
  assign sclk_rise = ~prev_r[0] & sclk_s;
  assign fs_fall   = prev_r[2] & ~fs_s;
  assign fs_rise   = ~prev_r[2] & fs_s;

  // Load request: after sixteen bits on the next rise, or an early frame rise
  always_comb
  begin
    xfer = 1'b0;
    unique case (state_r)
      QDL_D_IDLE:  xfer = 1'b0;
      QDL_D_SHIFT: xfer = fs_rise;
      QDL_D_WAIT:  xfer = sclk_rise | fs_rise;
      default:     xfer = 1'b0;
    endcase
    if (sel_n_s)
    begin
      xfer = 1'b0;
    end
  end

  assign xfer_chan = {shift_r[`QDL_SEL_HI_BIT], shift_r[`QDL_SEL_LO_BIT]};

  // Frame tracking; select may be tied low for a single device
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_r <= QDL_D_IDLE;
    end
    else if (sel_n_s)
    begin
      state_r <= QDL_D_IDLE;
    end
    else if (fs_fall)
    begin
      state_r <= QDL_D_SHIFT;
    end
    else if (xfer)
    begin
      state_r <= QDL_D_IDLE;
    end
    else if (state_r == QDL_D_SHIFT && sclk_fall && bit_cnt_r == `QDL_LAST_BIT_IDX)
    begin
      state_r <= QDL_D_WAIT;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      bit_cnt_r <= 4'h0;
      shift_r   <= 16'h0000;
    end
    else if (fs_fall && !sel_n_s)
    begin
      bit_cnt_r <= 4'h0;
    end
    else if (state_r == QDL_D_SHIFT && sclk_fall && !sel_n_s)
    begin
      shift_r   <= {shift_r[`QDL_WORD_BITS-2:0], sdata_s};
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // Per-channel input latches, only the addressed one changes
  for (genvar i = 0; i < `QDL_CHANNELS; i++)
  begin : g_chan
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
      begin
        latch_code_r[i]  <= 12'h000;
        latch_fast_r[i]  <= 1'b0;
        latch_sleep_r[i] <= 1'b0;
      end
      else if (xfer && xfer_chan == 2'(i))
      begin
        latch_code_r[i]  <= shift_r[`QDL_CODE_MSB:0];
        latch_fast_r[i]  <= shift_r[`QDL_SPEED_BIT];
        latch_sleep_r[i] <= shift_r[`QDL_SLEEP_BIT];
      end
    end

    // Outputs follow the latches while latch update is held low
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
      begin
        chan_code[i] <= 12'h000;
        chan_fast[i] <= 1'b0;
      end
      else if (!latch_update_n_n_s)
      begin
        chan_code[i] <= latch_code_r[i];
        chan_fast[i] <= latch_fast_r[i];
      end
    end
  end

  // Software power down follows the sleep bit of the latest word
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sleep_r <= 1'b0;
    end
    else if (xfer)
    begin
      sleep_r <= shift_r[`QDL_SLEEP_BIT];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      amp_enable <= 1'b0;
    end
    else
    begin
      amp_enable <= hw_pd_s2_r & ~sleep_r;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      word_loaded <= 1'b0;
    end
    else
    begin
      word_loaded <= xfer;
    end
  end

endmodule : qdl_device
`default_nettype wire

// ===== rtl/qdl_controller.sv
// Controller end: AXI4-Lite register slave driving the serial link
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`include "qdl_consts.svh"
`default_nettype none
module qdl_controller
  import qdl_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // AXI4-Lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial link
  qdl_link_if.ctl          link
);

  localparam logic [3:0] HALF = 4'(`QDL_SCLK_HALF_CYC);
  localparam logic [3:0] LATCH_UPDATE_N = 4'(`QDL_LATCH_UPDATE_N_CYC);

  logic [3:0]        aw_addr_r;
  logic              aw_got_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              w_got_r;
  logic              wr_go;
  logic [1:0]        ctrl_r;
  qdl_word_type      word_r;
  qdl_word_type      tx_sh_r;
  logic              start_r;
  logic              latch_update_n_go_r;
  logic [3:0]        latch_update_n_cnt_r;
  qdl_ctl_state_type state_r;
  logic [3:0]        tmr_r;
  logic [3:0]        bit_r;
  logic [31:0]       rd_val;
  logic              rd_ok;

  assign wr_go = aw_got_r & w_got_r & ~s_axi_bvalid;

  // Address and data taken in either order
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      aw_got_r      <= 1'b0;
      aw_addr_r     <= 4'h0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      aw_got_r      <= 1'b1;
      aw_addr_r     <= s_axi_awaddr;
    end
    else
    begin
      if (wr_go)
      begin
        aw_got_r <= 1'b0;
      end
      s_axi_awready <= ~aw_got_r & ~s_axi_bvalid;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_wready <= 1'b0;
      w_got_r      <= 1'b0;
      w_data_r     <= 32'h0;
      w_strb_r     <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      w_got_r      <= 1'b1;
      w_data_r     <= s_axi_wdata;
      w_strb_r     <= s_axi_wstrb;
    end
    else
    begin
      if (wr_go)
      begin
        w_got_r <= 1'b0;
      end
      s_axi_wready <= ~w_got_r & ~s_axi_bvalid;
    end
  end

  // Register writes and response
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `QDL_RESP_OKAY;
      ctrl_r       <= `QDL_CTRL_RESET;
      word_r       <= 16'h0000;
      start_r      <= 1'b0;
      latch_update_n_go_r    <= 1'b0;
    end
    else
    begin
      start_r   <= 1'b0;
      latch_update_n_go_r <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `QDL_RESP_OKAY;
        unique case (aw_addr_r)
          `QDL_OFS_CTRL:
          begin
            if (w_strb_r[0])
            begin
              ctrl_r <= w_data_r[1:0];
            end
          end
          `QDL_OFS_DATA:
          begin
            if (w_strb_r[1:0] == 2'h3 && state_r == QDL_C_IDLE)
            begin
              word_r  <= w_data_r[15:0];
              start_r <= 1'b1;
            end
          end
          `QDL_OFS_LATCH:
          begin
            latch_update_n_go_r <= w_strb_r[0] & w_data_r[0];
          end
          `QDL_OFS_STATUS:
          begin
            s_axi_bresp <= `QDL_RESP_OKAY;
          end
          default:
          begin
            s_axi_bresp <= `QDL_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Read decode
  always_comb
  begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      `QDL_OFS_CTRL:   rd_val = {30'h0, ctrl_r};
      `QDL_OFS_DATA:   rd_val = {16'h0, word_r};
      `QDL_OFS_LATCH:  rd_val = 32'h0;
      `QDL_OFS_STATUS: rd_val = {30'h0, ~link.latch_update_n, state_r != QDL_C_IDLE};
      default:         rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `QDL_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_ok ? `QDL_RESP_OKAY : `QDL_RESP_SLVERR;
    end
    else
    begin
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_rvalid;
    end
  end

  // Latch update pulse on request
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      latch_update_n_cnt_r          <= 4'h0;
      link.latch_update_n <= 1'b1;
    end
    else if (latch_update_n_go_r)
    begin
      latch_update_n_cnt_r          <= LATCH_UPDATE_N;
      link.latch_update_n <= 1'b0;
    end
    else if (latch_update_n_cnt_r != 4'h0)
    begin
      latch_update_n_cnt_r          <= latch_update_n_cnt_r - 4'h1;
      link.latch_update_n <= (latch_update_n_cnt_r == 4'h1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      link.hw_powerdown_n <= 1'b1;
    end
    else
    begin
      link.hw_powerdown_n <= ~ctrl_r[`QDL_CTRL_HW_PD];
    end
  end

  // Frame sequencer, one whole 16-bit word per frame
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_r              <= QDL_C_IDLE;
      tmr_r                <= 4'h0;
      bit_r                <= 4'h0;
      tx_sh_r              <= 16'h0000;
      link.sclk            <= 1'b0;
      link.sdata           <= 1'b0;
      link.frame_sync      <= 1'b1;
      link.device_select_n <= 1'b1;
    end
    else if (state_r == QDL_C_IDLE)
    begin
      link.device_select_n <= ctrl_r[`QDL_CTRL_SEL_EN];
      if (start_r)
      begin
        link.device_select_n <= 1'b0;
        tx_sh_r              <= word_r;
        tmr_r                <= HALF;
        state_r              <= QDL_C_SEL;
      end
    end
    else if (tmr_r != 4'h1)
    begin
      tmr_r <= tmr_r - 4'h1;
    end
    else
    begin
      tmr_r <= HALF;
      unique case (state_r)
        QDL_C_SEL:
        begin
          link.frame_sync <= 1'b0;
          link.sdata      <= tx_sh_r[15];
          link.sclk       <= 1'b1;
          bit_r           <= 4'h0;
          state_r         <= QDL_C_HIGH;
        end
        QDL_C_HIGH:
        begin
          link.sclk <= 1'b0;
          state_r   <= QDL_C_LOW;
        end
        QDL_C_LOW:
        begin
          link.sclk <= 1'b1;
          if (bit_r == `QDL_LAST_BIT_IDX)
          begin
            state_r <= QDL_C_TAIL;
          end
          else
          begin
            bit_r      <= bit_r + 4'h1;
            tx_sh_r    <= {tx_sh_r[14:0], 1'b0};
            link.sdata <= tx_sh_r[14];
            state_r    <= QDL_C_HIGH;
          end
        end
        QDL_C_TAIL:
        begin
          link.sclk       <= 1'b0;
          link.frame_sync <= 1'b1;
          state_r         <= QDL_C_DONE;
        end
        QDL_C_DONE:
        begin
          link.device_select_n <= ctrl_r[`QDL_CTRL_SEL_EN];
          state_r              <= QDL_C_IDLE;
        end
        default:
        begin
          state_r <= QDL_C_IDLE;
        end
      endcase
    end
  end

endmodule : qdl_controller
`default_nettype wire

// ===== verification/qdl_chk.sv
// Timing and framing checks on the quad loader serial link
`default_nettype none
module qdl_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial link
  input wire logic sclk,
  input wire logic sdata,
  input wire logic frame_sync,
  input wire logic device_select_n,
  input wire logic latch_update_n,
  input wire logic hw_powerdown_n
);
  logic [4:0] falls_r;
  logic [4:0] rises_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Clock falls within the current frame
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || $fell(frame_sync))
      falls_r <= 5'h0;
    else if ($fell(sclk) && !frame_sync)
      falls_r <= falls_r + 5'h1;
  end

  // Clock rises within the frame, the one at frame start included
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rises_r <= 5'h0;
    else if ($fell(frame_sync))
      rises_r <= 5'h1;
    else if ($rose(sclk) && !frame_sync)
      rises_r <= rises_r + 5'h1;
  end

  sel_before_frame_a: assert property ($fell(frame_sync) |->
    !device_select_n && $past(device_select_n, 4) == 1'b0)
    else $error("frame started without select held low");
  sel_in_frame_a: assert property (!frame_sync |-> !device_select_n)
    else $error("select high inside a frame");
  sel_release_a: assert property ($rose(device_select_n) |->
    frame_sync && $past(frame_sync, 4))
    else $error("select released too early");
  data_stable_a: assert property ($fell(sclk) |-> $stable(sdata))
    else $error("data moved at clock fall");
  clk_high_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("clock high phase wrong");
  clk_low_a: assert property ($fell(sclk) && !frame_sync |-> (!sclk) [*4] ##1 sclk)
    else $error("clock low phase wrong");
  idle_clk_a: assert property (frame_sync && $past(frame_sync) |-> !sclk)
    else $error("clock running outside a frame");
  sixteen_bits_a: assert property ($rose(frame_sync) |-> falls_r == 5'h10)
    else $error("frame did not carry sixteen bits");
  extra_rise_a: assert property ($rose(frame_sync) |-> rises_r == 5'h11)
    else $error("no update rise after last bit");
  update_pulse_a: assert property ($fell(latch_update_n) |->
    (!latch_update_n) [*5] ##1 latch_update_n)
    else $error("latch update pulse width wrong");
endmodule : qdl_chk
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench joining the quad loader controller and device
`include "qdl_consts.svh"
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %0h, expected %0h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               core_clk;
  logic               rst_n;
  logic [3:0]         awaddr, araddr, wstrb;
  logic [31:0]        wdata, rdata;
  logic               awvalid, wvalid, bready, arvalid, rready;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [1:0]         bresp, rresp;
  logic [3:0][11:0]   code, code2;
  logic [3:0]         fast, fast2;
  logic               amp, amp2, loaded, loaded2;
  logic [15:0]        mon_w;
  logic               sclk_d;
  int                 errors = 0;
  int                 samples_checked = 0;

  qdl_link_if link ();
  qdl_link_if link2 ();

  qdl_controller u_qdl_controller (.core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link(link.ctl));
  qdl_device u_qdl_device (.core_clk(core_clk), .rst_n(rst_n), .link(link.dev),
    .chan_code(code), .chan_fast(fast), .amp_enable(amp), .word_loaded(loaded));
  // Second device on a link driven by the bench itself
  qdl_device u_qdl_device_2 (.core_clk(core_clk), .rst_n(rst_n), .link(link2.dev),
    .chan_code(code2), .chan_fast(fast2), .amp_enable(amp2), .word_loaded(loaded2));
  qdl_chk u_qdl_chk (.core_clk(core_clk), .rst_n(rst_n), .sclk(link.sclk),
    .sdata(link.sdata), .frame_sync(link.frame_sync),
    .device_select_n(link.device_select_n), .latch_update_n(link.latch_update_n),
    .hw_powerdown_n(link.hw_powerdown_n));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Word seen on the wire, one bit per clock fall
  always @(posedge core_clk)
  begin
    sclk_d <= link.sclk;
    if (sclk_d && !link.sclk && !link.frame_sync)
      mon_w <= {mon_w[14:0], link.sdata};
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge core_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
    `CHK(bresp, `QDL_RESP_OKAY)
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge core_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    d = rdata;
    rready <= 1'b0;
    `CHK(rresp, er)
  endtask : axi_read

  task automatic poll(input int b);
    logic [31:0] d;
    int          n;
    n = 0;
    d = 32'h1 << b;
    while (d[b] !== 1'b0 && n < 50)
    begin
      axi_read(`QDL_OFS_STATUS, d, `QDL_RESP_OKAY);
      n++;
    end
    `CHK(d[b], 1'b0)
  endtask : poll

  task automatic send(input logic [15:0] w);
    int n;
    axi_write(`QDL_OFS_DATA, {16'h0, w}, 4'h3);
    n = 0;
    while (loaded !== 1'b1 && n < 400)
    begin
      @(posedge core_clk);
      n++;
    end
    `CHK(loaded, 1'b1)
    poll(`QDL_STAT_BUSY);
    `CHK(mon_w, w)
  endtask : send

  task automatic latch();
    axi_write(`QDL_OFS_LATCH, 32'h1, 4'hf);
    poll(`QDL_STAT_LATCH);
    repeat (4) @(posedge core_clk);
  endtask : latch

  // Bench-made frame, 160 ns clock, update rise held before the frame ends
  task automatic bb(input logic [15:0] w, input logic sel_n);
    int i;
    link2.device_select_n <= sel_n;
    repeat (4) @(posedge core_clk);
    link2.frame_sync <= 1'b0;
    for (i = 15; i >= 0; i--)
    begin
      link2.sclk <= 1'b1;
      link2.sdata <= w[i];
      repeat (4) @(posedge core_clk);
      link2.sclk <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    link2.sclk <= 1'b1;
    repeat (8) @(posedge core_clk);
    if (!sel_n)
      `CHK(code2[w[15:14]], w[11:0])
    link2.sclk <= 1'b0;
    link2.frame_sync <= 1'b1;
    link2.sdata <= ~w[0];
    repeat (4) @(posedge core_clk);
    link2.device_select_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : bb

  task automatic t_reset();
    logic [31:0] d;
    `CHK(code, 48'h0)
    `CHK(fast, 4'h0)
    `CHK(amp, 1'b1)
    `CHK(link.device_select_n, 1'b0)
    axi_read(`QDL_OFS_CTRL, d, `QDL_RESP_OKAY);
    `CHK(d, 32'h0)
    axi_read(4'h2, d, `QDL_RESP_SLVERR);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_channels();
    logic [11:0] cv [4];
    logic [31:0] d;
    int          i;
    cv = '{12'h001, 12'h800, 12'h7ff, 12'hfff};
    for (i = 0; i < 4; i++)
      send({i[1:0], 1'b0, i[0], cv[i]});
    `CHK(code, 48'h0)
    latch();
    `CHK(code, {cv[3], cv[2], cv[1], cv[0]})
    `CHK(fast, 4'b1010)
    axi_read(`QDL_OFS_DATA, d, `QDL_RESP_OKAY);
    `CHK(d[15:0], 16'hdfff)
    send(16'h4123);
    latch();
    `CHK(code, {12'hfff, 12'h7ff, 12'h123, 12'h001})
    `CHK(fast, 4'b1000)
    $display("t_channels done");
  endtask : t_channels

  task automatic t_power();
    send(16'hf555);
    `CHK(amp, 1'b0)
    send(16'hd555);
    latch();
    `CHK(amp, 1'b1)
    `CHK(code[3], 12'h555)
    axi_write(`QDL_OFS_CTRL, 32'h2, 4'h1);
    repeat (6) @(posedge core_clk);
    `CHK(link.hw_powerdown_n, 1'b0)
    `CHK(amp, 1'b0)
    axi_write(`QDL_OFS_CTRL, 32'h1, 4'h1);
    repeat (6) @(posedge core_clk);
    `CHK(link.device_select_n, 1'b1)
    `CHK(amp, 1'b1)
    send(16'h00ab);
    latch();
    `CHK(code[0], 12'h0ab)
    axi_write(`QDL_OFS_CTRL, 32'h0, 4'h1);
    $display("t_power done");
  endtask : t_power

  task automatic t_link2();
    bb(16'h9c35, 1'b1);
    `CHK(code2, 48'h0)
    bb(16'h9c35, 1'b0);
    `CHK(fast2, 4'b0100)
    `CHK(amp2, 1'b1)
    $display("t_link2 done");
  endtask : t_link2

  // Frame cut after four bits: the early frame rise loads what the shifter holds
  task automatic t_early();
    logic [3:0] nib;
    int         i;
    nib = 4'ha;
    link2.device_select_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    link2.frame_sync <= 1'b0;
    for (i = 3; i >= 0; i--)
    begin
      link2.sclk <= 1'b1;
      link2.sdata <= nib[i];
      repeat (4) @(posedge core_clk);
      link2.sclk <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    link2.frame_sync <= 1'b1;
    repeat (8) @(posedge core_clk);
    `CHK(code2, {12'h35a, 12'hc35, 24'h0})
    link2.device_select_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    $display("t_early done");
  endtask : t_early

  // Second reset in mid-run must clear every input latch again
  task automatic t_rerun();
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK(code2, 48'h0)
    `CHK(fast2, 4'h0)
    latch();
    `CHK(code, 48'h0)
    `CHK(fast, 4'h0)
    $display("t_rerun done");
  endtask : t_rerun

  initial
  begin
    rst_n = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wstrb = 4'h0;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    link2.sclk = 1'b0;
    link2.sdata = 1'b0;
    link2.frame_sync = 1'b1;
    link2.device_select_n = 1'b1;
    link2.latch_update_n = 1'b0;
    link2.hw_powerdown_n = 1'b1;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_channels();
    t_power();
    t_link2();
    t_early();
    t_rerun();
    test_done();
  end

  initial
  begin
    repeat (40000) @(posedge core_clk);
    errors++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
